// ### pdr_pkg.sv
package pdr_pkg;

  // ==========================================================================
  // Register map as word indexes; the bus byte address is four times the index.
  localparam int unsigned PDR_ADDR_W = 16;
  localparam logic [15:0] PDR_OFF_PORT0 = 16'hFF20;
  localparam logic [15:0] PDR_OFF_PORT2 = 16'hFF22;
  localparam logic [15:0] PDR_OFF_PORT3 = 16'hFF23;
  localparam logic [15:0] PDR_OFF_PORT6 = 16'hFF26;
  localparam logic [15:0] PDR_OFF_PORT7 = 16'hFF27;
  localparam logic [15:0] PDR_OFF_DATA_BASE = 16'hFF00;
  localparam logic [7:0] PDR_DIR_RESET = 8'hFF;
  localparam logic [7:0] PDR_DATA_RESET = 8'h00;

  // ==========================================================================
  // Implemented direction bits per port on the largest variant.
  localparam logic [7:0] PDR_IMPL_PORT0 = 8'h07;
  localparam logic [7:0] PDR_IMPL_PORT2 = 8'hFF;
  localparam logic [7:0] PDR_IMPL_PORT3 = 8'hFF;
  localparam logic [7:0] PDR_IMPL_PORT6 = 8'h03;
  localparam logic [7:0] PDR_IMPL_PORT7 = 8'h01;

  localparam int unsigned PDR_NPORT = 5;
  localparam logic [1:0] PDR_RESP_OKAY = 2'b00;
  localparam logic [1:0] PDR_RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    PDR_P0,
    PDR_P2,
    PDR_P3,
    PDR_P6,
    PDR_P7
  } pdr_port_t;

  typedef struct packed {
    logic [7:0] port0;
    logic [7:0] port2;
    logic [7:0] port3;
    logic [7:0] port6;
    logic [7:0] port7;
  } pdr_ports_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pdr_axi_out_t;

endpackage : pdr_pkg

// ### pdr_sync.sv
`timescale 1ns/1ps
module pdr_sync
  import pdr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire pdr_pkg::pdr_ports_t padIn,
  output pdr_pkg::pdr_ports_t padSync
);
  typedef struct packed {
    pdr_ports_t meta;
    pdr_ports_t sync;
  } pdr_sync_state_t;

  pdr_sync_state_t s_q;
  pdr_sync_state_t s_d;

  always_comb begin
    s_d.meta = padIn;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign padSync = s_q.sync;

endmodule : pdr_sync

// ### pdr_port_direction.sv
// Summary of operation
// RULE1: One independent direction bit per port pin.
// RULE2: Bit zero drives pin, one makes input.
// RULE3: Reset loads all direction registers with ones.
// RULE4: Byte writes and single-bit writes both supported.
// RULE5: Software keeps analog pins in input mode.
// RULE6: Largest variant: unimplemented bits written as ones.
// RULE7: Smallest variant: listed port 2/3 bits ones.
// RULE8: Middle variant: listed bits written as ones.
// RULE9: 32-pin version: two absent bits written zero.
// RULE10: Data read: pin if input, latch if output.
// RULE11: Enable is inverse of bit; unimplemented read one.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module pdr_port_direction
  import pdr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pdr_pkg::pdr_ports_t padIn,
  output pdr_pkg::pdr_ports_t padOut,
  output pdr_pkg::pdr_ports_t padOe
);
  import pdr_pkg::*;

  // ==========================================================================
  // State.
  typedef struct packed {
    pdr_ports_t dir;
    pdr_ports_t latch;
    pdr_ports_t oe;
    logic [15:0] awAddr;
    logic awHeld;
    logic [7:0] wByte;
    logic wEn;
    logic wHeld;
    pdr_axi_out_t axi;
  } pdr_state_t;

  pdr_state_t s_q;
  pdr_state_t s_d;
  pdr_ports_t padSync;

  pdr_sync pdr_sync_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .padIn(padIn),
    .padSync(padSync)
  );

  // ==========================================================================
  // Decode helpers.

  // Direction register index for a register word index; a miss returns valid low.
  function automatic logic dirHit(input logic [15:0] a, output pdr_port_t p);
    p = PDR_P0;
    dirHit = 1'b1;
    case (a)
      PDR_OFF_PORT0: p = PDR_P0;
      PDR_OFF_PORT2: p = PDR_P2;
      PDR_OFF_PORT3: p = PDR_P3;
      PDR_OFF_PORT6: p = PDR_P6;
      PDR_OFF_PORT7: p = PDR_P7;
      default: dirHit = 1'b0;
    endcase
  endfunction : dirHit

  // Port data registers sit at the same low nibble below the direction block.
  function automatic logic dataHit(input logic [15:0] a, output pdr_port_t p);
    logic [15:0] d;
    d = a - PDR_OFF_DATA_BASE + PDR_OFF_PORT0;
    dataHit = dirHit(d, p);
  endfunction : dataHit

  function automatic logic [7:0] implMask(input pdr_port_t p);
    case (p)
      PDR_P0: implMask = PDR_IMPL_PORT0;
      PDR_P2: implMask = PDR_IMPL_PORT2;
      PDR_P3: implMask = PDR_IMPL_PORT3;
      PDR_P6: implMask = PDR_IMPL_PORT6;
      PDR_P7: implMask = PDR_IMPL_PORT7;
      default: implMask = 8'h00;
    endcase
  endfunction : implMask

  function automatic logic [7:0] pick(input pdr_ports_t v, input pdr_port_t p);
    case (p)
      PDR_P0: pick = v.port0;
      PDR_P2: pick = v.port2;
      PDR_P3: pick = v.port3;
      PDR_P6: pick = v.port6;
      PDR_P7: pick = v.port7;
      default: pick = 8'h00;
    endcase
  endfunction : pick

  function automatic pdr_ports_t place(input pdr_ports_t v, input pdr_port_t p,
                                       input logic [7:0] b);
    place = v;
    case (p)
      PDR_P0: place.port0 = b;
      PDR_P2: place.port2 = b;
      PDR_P3: place.port3 = b;
      PDR_P6: place.port6 = b;
      PDR_P7: place.port7 = b;
      default: place = v;
    endcase
  endfunction : place

  // ==========================================================================
  // Next state.
  always_comb begin
    pdr_port_t wp;
    pdr_port_t rp;
    logic wDir;
    logic wDat;
    logic rDir;
    logic rDat;
    logic [15:0] ra;
    logic [7:0] mask;
    logic [7:0] rb;
    wp = PDR_P0;
    rp = PDR_P0;
    wDir = 1'b0;
    wDat = 1'b0;
    rDir = 1'b0;
    rDat = 1'b0;
    ra = s_axi_araddr[17:2];
    mask = 8'h00;
    rb = 8'h00;
    s_d = s_q;
    s_d.axi.awready = 1'b0;
    s_d.axi.wready = 1'b0;
    s_d.axi.arready = 1'b0;

    // Write address and data are taken independently, in either order.
    if (s_axi_awvalid && !s_q.awHeld && !s_q.axi.awready) begin
      s_d.axi.awready = 1'b1;
      s_d.awAddr = s_axi_awaddr[17:2];
      s_d.awHeld = 1'b1;
    end
    if (s_axi_wvalid && !s_q.wHeld && !s_q.axi.wready) begin
      s_d.axi.wready = 1'b1;
      s_d.wByte = s_axi_wdata[7:0];
      s_d.wEn = s_axi_wstrb[0];
      s_d.wHeld = 1'b1;
    end

    // Both halves present and no response pending: commit the write.
    if (s_q.awHeld && s_q.wHeld && !s_q.axi.bvalid) begin
      wDir = dirHit(s_q.awAddr, wp);
      if (!wDir) begin
        wDat = dataHit(s_q.awAddr, wp);
      end
      if (s_q.wEn && wDir) begin
        // A bit write arrives as a whole byte read-modified by the CPU; only
        // changed bits differ, so each pin is still set on its own.
        mask = implMask(wp);
        s_d.dir = place(s_q.dir, wp, (s_q.wByte & mask) | ~mask); // RULE1 RULE4 RULE11
      end
      if (s_q.wEn && wDat) begin
        s_d.latch = place(s_q.latch, wp, s_q.wByte);
      end
      s_d.axi.bvalid = 1'b1;
      s_d.axi.bresp = (wDir || wDat) ? PDR_RESP_OKAY : PDR_RESP_SLVERR;
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
    end else if (s_q.axi.bvalid && s_axi_bready) begin
      s_d.axi.bvalid = 1'b0;
    end

    // The read answers on the edge that takes its address, one edge after arready rises, never before.
    if (s_q.axi.rvalid) begin
      if (s_axi_rready) begin
        s_d.axi.rvalid = 1'b0;
      end
    end else if (s_q.axi.arready) begin
      rDir = dirHit(ra, rp);
      if (rDir) begin
        mask = implMask(rp);
        rb = pick(s_q.dir, rp) | ~mask; // RULE11
      end else begin
        rDat = dataHit(ra, rp);
        if (rDat) begin
          // Input pins return the pad level, output pins the latch.
          rb = (pick(padSync, rp) & pick(s_q.dir, rp)) |
               (pick(s_q.latch, rp) & ~pick(s_q.dir, rp)); // RULE10
        end
      end
      s_d.axi.rvalid = 1'b1;
      s_d.axi.rdata = {24'h000000, rb};
      s_d.axi.rresp = (rDir || rDat) ? PDR_RESP_OKAY : PDR_RESP_SLVERR;
    end else if (s_axi_arvalid) begin
      s_d.axi.arready = 1'b1;
    end

    // Output driver on when the direction bit is zero.
    s_d.oe = ~s_d.dir; // RULE2 RULE11
  end

  // ==========================================================================
  // Registers.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.dir <= {PDR_NPORT{PDR_DIR_RESET}}; // RULE3
      s_q.latch <= {PDR_NPORT{PDR_DATA_RESET}};
      s_q.oe <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.axi.awready;
  assign s_axi_wready = s_q.axi.wready;
  assign s_axi_bvalid = s_q.axi.bvalid;
  assign s_axi_bresp = s_q.axi.bresp;
  assign s_axi_arready = s_q.axi.arready;
  assign s_axi_rvalid = s_q.axi.rvalid;
  assign s_axi_rdata = s_q.axi.rdata;
  assign s_axi_rresp = s_q.axi.rresp;
  assign padOut = s_q.latch;
  assign padOe = s_q.oe;

endmodule : pdr_port_direction

// ### pdr_port_direction_props.sv
`timescale 1ns/1ps
module pdr_port_direction_props
  import pdr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire pdr_pkg::pdr_ports_t padOe
);
  import pdr_pkg::*;
  // ==========
  // Checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  rst_oe_a: assert property ($rose(rst_n) |-> padOe == '0) else $error("oe not off");
  impl_oe_a: assert property ((padOe & ~{PDR_IMPL_PORT0, PDR_IMPL_PORT2, PDR_IMPL_PORT3,
    PDR_IMPL_PORT6, PDR_IMPL_PORT7}) == '0) else $error("unimplemented pin driven");
  oe_wr_a: assert property (!$stable(padOe) |-> $rose(s_axi_bvalid)) else $error("oe moved");
  wr_ans_a: assert property (s_axi_awvalid && s_axi_wvalid |-> ##[1:4] s_axi_bvalid)
    else $error("no write response");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  rd_ans_a: assert property (s_axi_arvalid && !s_axi_rvalid |-> ##[1:2] s_axi_rvalid)
    else $error("no read data");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("rdata moved");
  rd_impl_a: assert property (s_axi_arready && s_axi_araddr[17:2] == PDR_OFF_PORT0
    |=> s_axi_rdata[7:3] == 5'h1F) else $error("unimplemented bits not one");
endmodule : pdr_port_direction_props
bind pdr_port_direction pdr_port_direction_props i_pdr_port_direction_props (.*);

// ### pdr_port_direction_tb.sv
`timescale 1ns/1ps
module pdr_port_direction_tb;
  import pdr_pkg::*;
  // ==========
  // Bench
  logic clk_sys = 1'b0, rst_n = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  pdr_ports_t padIn = '0, padOut, padOe;
  int errCount = 0, cmpCount = 0, j;
  logic [7:0] lfsrQ = 8'h37, v;
  logic [39:0] oeE = '0;
  logic [33:0] rdQ[$];
  logic [1:0] bQ[$];
  logic [15:0] offs[5] = '{PDR_OFF_PORT0, PDR_OFF_PORT2, PDR_OFF_PORT3, PDR_OFF_PORT6,
    PDR_OFF_PORT7};
  logic [7:0] impl[5] = '{PDR_IMPL_PORT0, PDR_IMPL_PORT2, PDR_IMPL_PORT3, PDR_IMPL_PORT6,
    PDR_IMPL_PORT7};
  pdr_port_direction i_pdr_port_direction (.*);
  initial forever #2.5 clk_sys = ~clk_sys;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    cmpCount++;
    if (g !== e) begin
      errCount++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic s, input logic [1:0] r);
    int n = 0;
    @(posedge clk_sys);
    bQ.push_back(r);
    s_axi_awaddr <= {14'h0000, a, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= {3'b000, s};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) errCount++;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [33:0] e);
    int n = 0;
    @(posedge clk_sys);
    rdQ.push_back(e);
    s_axi_araddr <= {14'h0000, a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    if (n >= 50) errCount++;
  endtask : rd
  // Response checker pops the oldest expectation per completed transfer.
  always @(posedge clk_sys) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      chk("rdata", rdQ.pop_front(), {s_axi_rresp, s_axi_rdata});
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
      chk("bresp", bQ.pop_front(), s_axi_bresp);
    end
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial begin
    #100000;
    errCount++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) rd(offs[i], {PDR_RESP_OKAY, 24'h0, PDR_DIR_RESET});
    chk("oe", '0, padOe);
    $display("done: reset");
    for (int i = 0; i < 20; i++) begin
      j = i % 5;
      lfsrQ = lfsr(lfsrQ);
      v = lfsrQ | ~impl[j];
      wr(offs[j], v, 1'b1, PDR_RESP_OKAY);
      rd(offs[j], {PDR_RESP_OKAY, 24'h0, v});
      oeE[39 - 8 * j -: 8] = ~v & impl[j];
      chk("oe", oeE, padOe);
    end
    $display("done: byte writes");
    for (int b = 0; b < 8; b++) begin
      wr(PDR_OFF_PORT2, ~(8'h01 << b), 1'b1, PDR_RESP_OKAY);
      chk("oe2", 8'h01 << b, padOe.port2);
    end
    oeE[31:24] = 8'h80;
    $display("done: single pins");
    wr(PDR_OFF_PORT3, 8'h00, 1'b0, PDR_RESP_OKAY);
    wr(16'hFF21, 8'h00, 1'b1, PDR_RESP_SLVERR);
    rd(16'hFF21, {PDR_RESP_SLVERR, 32'h0});
    chk("oe", oeE, padOe);
    $display("done: refusals");
    lfsrQ = lfsr(lfsrQ);
    padIn.port2 <= lfsrQ;
    wr(PDR_OFF_DATA_BASE | 16'h0002, 8'hA5, 1'b1, PDR_RESP_OKAY);
    wr(PDR_OFF_PORT2, 8'hF0, 1'b1, PDR_RESP_OKAY);
    repeat (4) @(posedge clk_sys);
    rd(PDR_OFF_DATA_BASE | 16'h0002, {PDR_RESP_OKAY, 24'h0, 8'h05 | (lfsrQ & 8'hF0)});
    chk("out2", 8'hA5, padOut.port2);
    $display("done: data read");
    wr(PDR_OFF_PORT2, 8'hC4, 1'b1, PDR_RESP_OKAY);
    rd(PDR_OFF_PORT2, {PDR_RESP_OKAY, 24'h0, 8'hC4});
    wr(PDR_OFF_PORT0, 8'hFE, 1'b1, PDR_RESP_OKAY);
    rd(PDR_OFF_PORT0, {PDR_RESP_OKAY, 24'h0, 8'hFE});
    wr(PDR_OFF_PORT0, 8'hFD, 1'b1, PDR_RESP_OKAY);
    rd(PDR_OFF_PORT0, {PDR_RESP_OKAY, 24'h0, 8'hFD});
    chk("oe0", 8'h02, padOe.port0);
    wr(PDR_OFF_PORT7, 8'hFF, 1'b1, PDR_RESP_OKAY);
    rd(PDR_OFF_PORT7, {PDR_RESP_OKAY, 24'h0, 8'hFF});
    chk("oe7", 8'h00, padOe.port7);
    $display("done: variant writes");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    chk("oe", '0, padOe);
    rd(PDR_OFF_PORT2, {PDR_RESP_OKAY, 24'h0, PDR_DIR_RESET});
    $display("done: second reset");
    summarize();
  end
endmodule : pdr_port_direction_tb
